// file: rtl/clock_gear_map.svh
// register map, field positions, reset values and counts of the clock gear block
// Summary of operation
// - system clock from fast or slow oscillator
// - separate enable bit per oscillator
// - gear divides fast clock by 1..16
// - gear applies to the system clock only when source select is 0
// - reset: fast on, slow off, gear 100
// - warm-up length 2^8, 2^14 or 2^16
// - warm-up counts edges of started oscillator
// - bit 2 starts warm-up, reads busy
// - clock-out source: slow when 0, gear when 1
// - clock-out runs except static in stop
// - prescaler clock: gear/2 or fast/16/2
// - fast drive resets 1, never write 0
// - slow drive resets 1, 0 weakens it
// - external buffer bit forces second pin high
// - address latch pin off until enabled
// - guard blocks clock and memory-control writes
// - key 0x1F clears guard, else sets it
// - reset leaves guard cleared
`ifndef CLOCK_GEAR_MAP_SVH
`define CLOCK_GEAR_MAP_SVH
// register indexes, byte address is four times the index
`define CG_IDX_CTRL0        10'h0e0
`define CG_IDX_CTRL1        10'h0e1
`define CG_IDX_CTRL2        10'h0e2
`define CG_IDX_NOISE        10'h0e3
`define CG_IDX_KEY          10'h0e4
// clock_control_0 fields
`define CG_FAST_EN_BIT      7
`define CG_SLOW_EN_BIT      6
`define CG_WARMUP_BIT       2
`define CG_PRESC_LSB        0
// clock_control_1 fields
`define CG_SRC_SEL_BIT      3
`define CG_GEAR_LSB         0
// clock_control_2 fields
`define CG_CLKOUT_SEL_BIT   6
`define CG_WUP_LSB          4
// noise_control_register fields
`define CG_GUARD_BIT        7
`define CG_ALE_EN_BIT       5
`define CG_EXT_BUF_BIT      3
`define CG_FAST_DRV_BIT     1
`define CG_SLOW_DRV_BIT     0
// reset values
`define CG_RST_FAST_EN      1'b1
`define CG_RST_SLOW_EN      1'b0
`define CG_RST_SRC_SEL      1'b0
`define CG_RST_GEAR         3'h4
`define CG_RST_DRV          1'b1
// guard unlock key
`define CG_GUARD_KEY        8'h1f
// warm-up lengths in oscillator cycles
`define CG_WUP_SHORT        17'h0_0100
`define CG_WUP_MID          17'h0_4000
`define CG_WUP_LONG         17'h1_0000
// fixed divide code for the fast/16 prescaler source
`define CG_DIV16_CODE       3'h4
`endif

// file: rtl/clock_gear_pkg.sv
// types shared by the clock gear block
package clock_gear_pkg;
    typedef enum logic [0:0] {
        WUP_IDLE  = 1'b0,
        WUP_COUNT = 1'b1
    } warmup_state_t;
endpackage

// file: rtl/clock_divider.sv
// divides a sampled clock by a power of two, code changes only at a period start
`include "clock_gear_map.svh"
module clock_divider (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // source edges and divide code
    input  wire logic       src_edge,
    input  wire logic [2:0] div_code,
    // divided clock
    output logic            div_clk
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [2:0] code_r;
    logic [2:0] code_nxt;
    logic       out_r;
    logic       out_nxt;

    // half period minus one in source edges, codes above 4 clamp to 16
    function automatic logic [3:0] half_len(input logic [2:0] code);
        half_len = (code >= 3'h4) ? 4'hf : 4'((5'h01 << code) - 5'h01);
    endfunction

    // count edges, toggle at half period, take new code as the output falls
    always_comb begin
        cnt_nxt  = cnt_r;
        code_nxt = code_r;
        out_nxt  = out_r;
        if (src_edge) begin
            if (cnt_r >= half_len(code_r)) begin
                cnt_nxt = 4'h0;
                out_nxt = ~out_r;
                if (out_r) begin
                    code_nxt = div_code;
                end
            end else begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= 4'h0;
            code_r <= `CG_RST_GEAR;
            out_r  <= 1'b0;
        end else if (ce) begin
            cnt_r  <= cnt_nxt;
            code_r <= code_nxt;
            out_r  <= out_nxt;
        end
    end

    assign div_clk = out_r;
endmodule

// file: rtl/clock_gear_guard.sv
// system clock gear, warm-up timer, noise controls and write guard behind apb
//
// Implementation choice: register access over APB.
`include "clock_gear_map.svh"
module clock_gear_guard (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // oscillator clocks, sampled
    input  wire logic        fast_osc_clock,
    input  wire logic        slow_osc_clock,
    // mode and pin setup
    input  wire logic        stop_mode,
    input  wire logic        clkout_pin_direction,
    input  wire logic        clkout_pin_function,
    // generated clocks
    output logic             sys_clk,
    output logic             gear_clock,
    output logic             prescaler_clock,
    output logic             clock_out_pin_o,
    output logic             clock_out_pin_oe,
    // oscillator and pin controls
    output logic             fast_osc_enable,
    output logic             slow_osc_enable,
    output logic             fast_osc_drive_strength,
    output logic             slow_osc_drive_strength,
    output logic             ext_clock_buffer_mode,
    output logic             fast_osc_x2_force_high,
    output logic             addr_latch_oe,
    output logic             write_guard_active
);
    // registers
    logic       fast_en_r, fast_en_nxt, slow_en_r, slow_en_nxt;
    logic [1:0] presc_r, presc_nxt;
    logic       src_r, src_nxt;
    logic [2:0] gear_r, gear_nxt;
    logic       cosel_r, cosel_nxt;
    logic [1:0] wup_r, wup_nxt;
    logic       ale_r, ale_nxt, ext_r, ext_nxt;
    logic       fdrv_r, fdrv_nxt, sdrv_r, sdrv_nxt;
    logic       guard_r, guard_nxt;
    // bus answer
    logic        ready_r, ready_nxt, err_r, err_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // warm-up timer
    clock_gear_pkg::warmup_state_t wstate_r, wstate_nxt;
    logic [16:0] wcnt_r, wcnt_nxt;
    // clock path
    logic fast_q_r, slow_q_r, src_cur_r, src_cur_nxt;
    logic sys_r, sys_nxt, cout_r, cout_nxt, coe_r, coe_nxt;
    logic pre_r, pre_nxt, gear_prev_r, d16_prev_r;
    logic fast_edge, slow_rise, gear_clk, div16_clk, start_wup;
    logic write_take;
    logic [9:0] idx;
    logic [7:0] wbyte;

    // warm-up length for the selected code, code 00 taken as shortest
    function automatic logic [16:0] wup_len(input logic [1:0] code);
        case (code)
            2'h2:    wup_len = `CG_WUP_MID;
            2'h3:    wup_len = `CG_WUP_LONG;
            default: wup_len = `CG_WUP_SHORT;
        endcase
    endfunction

    // guarded registers
    function automatic logic is_guarded(input logic [9:0] i);
        is_guarded = (i == `CG_IDX_CTRL0) || (i == `CG_IDX_CTRL1)
                  || (i == `CG_IDX_CTRL2) || (i == `CG_IDX_NOISE);
    endfunction

    assign idx        = paddr[11:2];
    assign wbyte      = pwdata[7:0];
    assign write_take = psel & penable & ready_r & pwrite & ~err_r;
    assign fast_edge  = fast_osc_clock ^ fast_q_r;
    assign slow_rise  = slow_osc_clock & ~slow_q_r;
    assign start_wup  = write_take && (idx == `CG_IDX_CTRL0) && !guard_r
                      && wbyte[`CG_WARMUP_BIT];

    // gear clock from the fast oscillator
    clock_divider u_gear (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .src_edge (fast_edge),
        .div_code (gear_r),
        .div_clk  (gear_clk)
    );

    // fixed fast/16 source for the prescaler
    clock_divider u_div16 (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .src_edge (fast_edge),
        .div_code (`CG_DIV16_CODE),
        .div_clk  (div16_clk)
    );

    // register writes and guard
    always_comb begin
        fast_en_nxt = fast_en_r;
        slow_en_nxt = slow_en_r;
        presc_nxt   = presc_r;
        src_nxt     = src_r;
        gear_nxt    = gear_r;
        cosel_nxt   = cosel_r;
        wup_nxt     = wup_r;
        ale_nxt     = ale_r;
        ext_nxt     = ext_r;
        fdrv_nxt    = fdrv_r;
        sdrv_nxt    = sdrv_r;
        guard_nxt   = guard_r;
        if (write_take) begin
            if (idx == `CG_IDX_KEY) begin
                guard_nxt = (wbyte != `CG_GUARD_KEY);
            end else if (guard_r && is_guarded(idx)) begin
                guard_nxt = guard_r;
            end else if (idx == `CG_IDX_CTRL0) begin
                fast_en_nxt = wbyte[`CG_FAST_EN_BIT];
                slow_en_nxt = wbyte[`CG_SLOW_EN_BIT];
                presc_nxt   = wbyte[`CG_PRESC_LSB +: 2];
            end else if (idx == `CG_IDX_CTRL1) begin
                src_nxt  = wbyte[`CG_SRC_SEL_BIT];
                gear_nxt = wbyte[`CG_GEAR_LSB +: 3];
            end else if (idx == `CG_IDX_CTRL2) begin
                cosel_nxt = wbyte[`CG_CLKOUT_SEL_BIT];
                wup_nxt   = wbyte[`CG_WUP_LSB +: 2];
            end else if (idx == `CG_IDX_NOISE) begin
                ale_nxt  = wbyte[`CG_ALE_EN_BIT];
                ext_nxt  = wbyte[`CG_EXT_BUF_BIT];
                fdrv_nxt = wbyte[`CG_FAST_DRV_BIT];
                sdrv_nxt = wbyte[`CG_SLOW_DRV_BIT];
            end
        end
    end

    // apb answer: ready one cycle after setup, error on unmapped index
    always_comb begin
        ready_nxt = 1'b0;
        err_nxt   = 1'b0;
        rdata_nxt = rdata_r;
        if (psel && !penable) begin
            ready_nxt = 1'b1;
            rdata_nxt = 32'h0000_0000;
            if (idx == `CG_IDX_CTRL0) begin
                rdata_nxt[`CG_FAST_EN_BIT]        = fast_en_r;
                rdata_nxt[`CG_SLOW_EN_BIT]        = slow_en_r;
                rdata_nxt[`CG_WARMUP_BIT]         = (wstate_r == clock_gear_pkg::WUP_COUNT);
                rdata_nxt[`CG_PRESC_LSB +: 2]     = presc_r;
            end else if (idx == `CG_IDX_CTRL1) begin
                rdata_nxt[`CG_SRC_SEL_BIT]        = src_r;
                rdata_nxt[`CG_GEAR_LSB +: 3]      = gear_r;
            end else if (idx == `CG_IDX_CTRL2) begin
                rdata_nxt[`CG_CLKOUT_SEL_BIT]     = cosel_r;
                rdata_nxt[`CG_WUP_LSB +: 2]       = wup_r;
            end else if (idx == `CG_IDX_NOISE) begin
                rdata_nxt[`CG_GUARD_BIT]          = guard_r;
                rdata_nxt[`CG_ALE_EN_BIT]         = ale_r;
                rdata_nxt[`CG_EXT_BUF_BIT]        = ext_r;
                rdata_nxt[`CG_FAST_DRV_BIT]       = fdrv_r;
                rdata_nxt[`CG_SLOW_DRV_BIT]       = sdrv_r;
            end else if (idx != `CG_IDX_KEY) begin
                err_nxt = 1'b1;
            end
        end
    end

    // warm-up timer counts edges of the oscillator not driving the system
    always_comb begin
        wstate_nxt = wstate_r;
        wcnt_nxt   = wcnt_r;
        case (wstate_r)
            clock_gear_pkg::WUP_IDLE: begin
                if (start_wup) begin
                    wstate_nxt = clock_gear_pkg::WUP_COUNT;
                    wcnt_nxt   = 17'h0_0000;
                end
            end
            clock_gear_pkg::WUP_COUNT: begin
                if (start_wup) begin
                    wcnt_nxt = 17'h0_0000;
                end else if (src_cur_r ? (fast_edge & fast_osc_clock) : slow_rise) begin
                    wcnt_nxt = wcnt_r + 17'h0_0001;
                    if (wcnt_nxt >= wup_len(wup_r)) begin
                        wstate_nxt = clock_gear_pkg::WUP_IDLE;
                    end
                end
            end
            default: wstate_nxt = clock_gear_pkg::WUP_IDLE;
        endcase
    end

    // clock path: source switch while gear, slow and system clock are all low
    always_comb begin
        src_cur_nxt = src_cur_r;
        if (!gear_clk && !slow_q_r && !sys_r) begin
            src_cur_nxt = src_r;
        end
        // fast source gives the gear clock halved, slow source passes through
        sys_nxt = sys_r;
        if (src_cur_r) begin
            sys_nxt = slow_q_r;
        end else if (gear_clk && !gear_prev_r) begin
            sys_nxt = ~sys_r;
        end
        cout_nxt = cout_r;
        if (!stop_mode) begin
            cout_nxt = cosel_r ? gear_clk : slow_q_r;
        end
        coe_nxt = clkout_pin_direction & clkout_pin_function;
        pre_nxt = pre_r;
        if (presc_r == 2'h0 ? (gear_clk && !gear_prev_r) : (div16_clk && !d16_prev_r)) begin
            pre_nxt = ~pre_r;
        end
    end

    // all state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_en_r   <= `CG_RST_FAST_EN;
            slow_en_r   <= `CG_RST_SLOW_EN;
            presc_r     <= 2'h0;
            src_r       <= `CG_RST_SRC_SEL;
            gear_r      <= `CG_RST_GEAR;
            cosel_r     <= 1'b0;
            wup_r       <= 2'h0;
            ale_r       <= 1'b0;
            ext_r       <= 1'b0;
            fdrv_r      <= `CG_RST_DRV;
            sdrv_r      <= `CG_RST_DRV;
            guard_r     <= 1'b0;
            ready_r     <= 1'b0;
            err_r       <= 1'b0;
            rdata_r     <= 32'h0000_0000;
            wstate_r    <= clock_gear_pkg::WUP_IDLE;
            wcnt_r      <= 17'h0_0000;
            fast_q_r    <= 1'b0;
            slow_q_r    <= 1'b0;
            src_cur_r   <= `CG_RST_SRC_SEL;
            sys_r       <= 1'b0;
            cout_r      <= 1'b0;
            coe_r       <= 1'b0;
            pre_r       <= 1'b0;
            gear_prev_r <= 1'b0;
            d16_prev_r  <= 1'b0;
        end else if (ce) begin
            fast_en_r   <= fast_en_nxt;
            slow_en_r   <= slow_en_nxt;
            presc_r     <= presc_nxt;
            src_r       <= src_nxt;
            gear_r      <= gear_nxt;
            cosel_r     <= cosel_nxt;
            wup_r       <= wup_nxt;
            ale_r       <= ale_nxt;
            ext_r       <= ext_nxt;
            fdrv_r      <= fdrv_nxt;
            sdrv_r      <= sdrv_nxt;
            guard_r     <= guard_nxt;
            ready_r     <= ready_nxt;
            err_r       <= err_nxt;
            rdata_r     <= rdata_nxt;
            wstate_r    <= wstate_nxt;
            wcnt_r      <= wcnt_nxt;
            fast_q_r    <= fast_osc_clock;
            slow_q_r    <= slow_osc_clock;
            src_cur_r   <= src_cur_nxt;
            sys_r       <= sys_nxt;
            cout_r      <= cout_nxt;
            coe_r       <= coe_nxt;
            pre_r       <= pre_nxt;
            gear_prev_r <= gear_clk;
            d16_prev_r  <= div16_clk;
        end
    end

    // outputs, all from flip-flops
    assign prdata                  = rdata_r;
    assign pready                  = ready_r;
    assign pslverr                 = err_r;
    assign sys_clk                 = sys_r;
    assign gear_clock              = gear_clk;
    assign prescaler_clock         = pre_r;
    assign clock_out_pin_o         = cout_r;
    assign clock_out_pin_oe        = coe_r;
    assign fast_osc_enable         = fast_en_r;
    assign slow_osc_enable         = slow_en_r;
    assign fast_osc_drive_strength = fdrv_r;
    assign slow_osc_drive_strength = sdrv_r;
    assign ext_clock_buffer_mode   = ext_r;
    assign fast_osc_x2_force_high  = ext_r;
    assign addr_latch_oe           = ale_r;
    assign write_guard_active      = guard_r;
endmodule

// file: verif/clock_gear_guard_sva.sv
// concurrent checks on the ports of the clock gear block
`include "clock_gear_map.svh"
module clock_gear_guard_sva (
    // clock, reset, enable
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // mode and controls
    input wire logic        stop_mode,
    input wire logic        clock_out_pin_o,
    input wire logic        fast_osc_enable,
    input wire logic        slow_osc_enable,
    input wire logic        fast_osc_drive_strength,
    input wire logic        slow_osc_drive_strength,
    input wire logic        ext_clock_buffer_mode,
    input wire logic        fast_osc_x2_force_high,
    input wire logic        addr_latch_oe,
    input wire logic        write_guard_active
);
    logic [9:0] idx;
    logic       wr;
    logic [7:0] wd_nxt;
    logic [7:0] wd_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // committed write and its data, kept one cycle
    assign idx = paddr[11:2];
    assign wr  = psel && penable && pready && pwrite && ce;
    always_comb wd_nxt = pwdata[7:0];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_r <= 8'h00;
        end else begin
            wd_r <= wd_nxt;
        end
    end
    a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_reset_state: assert property ($rose(rst_n) |->
        fast_osc_enable && !slow_osc_enable && fast_osc_drive_strength && slow_osc_drive_strength
        && !write_guard_active && !addr_latch_oe && !ext_clock_buffer_mode)
        else $error("wrong control state after reset");
    a_x2_follows_buf: assert property (fast_osc_x2_force_high == ext_clock_buffer_mode)
        else $error("second pin force differs from buffer mode");
    a_guard_blocks: assert property (wr && write_guard_active && idx >= `CG_IDX_CTRL0
        && idx <= `CG_IDX_NOISE |=> $stable({fast_osc_enable, slow_osc_enable, addr_latch_oe,
        ext_clock_buffer_mode, fast_osc_drive_strength, slow_osc_drive_strength}))
        else $error("guarded write changed a control");
    a_key_sets_guard: assert property (wr && idx == `CG_IDX_KEY |=>
        write_guard_active == (wd_r != `CG_GUARD_KEY))
        else $error("guard flag does not follow key");
    a_noise_write: assert property (wr && !write_guard_active && idx == `CG_IDX_NOISE |=>
        addr_latch_oe == wd_r[5] && ext_clock_buffer_mode == wd_r[3]
        && fast_osc_drive_strength == wd_r[1] && slow_osc_drive_strength == wd_r[0])
        else $error("noise controls not written");
    a_osc_enables: assert property (wr && !write_guard_active && idx == `CG_IDX_CTRL0 |=>
        {fast_osc_enable, slow_osc_enable} == wd_r[7:6])
        else $error("oscillator enables not written");
    a_unmapped_error: assert property (pready |-> pslverr == (idx < `CG_IDX_CTRL0 || idx > `CG_IDX_KEY))
        else $error("error response wrong for address");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_stop_static: assert property (stop_mode [*4] |=> $stable(clock_out_pin_o))
        else $error("clock-out moves in stop mode");
    c_key_write: cover property (wr && idx == `CG_IDX_KEY);
    c_refused: cover property (pready && pslverr);
    c_stop_hold: cover property (stop_mode [*4]);
endmodule
bind clock_gear_guard clock_gear_guard_sva i_clock_gear_guard_sva (
    .clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stop_mode, .clock_out_pin_o, .fast_osc_enable, .slow_osc_enable, .fast_osc_drive_strength,
    .slow_osc_drive_strength, .ext_clock_buffer_mode, .fast_osc_x2_force_high, .addr_latch_oe,
    .write_guard_active
);

// file: verif/system_clock_gear_and_guard_tb.sv
// self-checking bench for the clock gear, warm-up timer and write guard
`include "clock_gear_map.svh"
module system_clock_gear_and_guard_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, ce, psel, penable, pwrite, stop_mode, err, prv, cur;
    logic        clkout_pin_direction, clkout_pin_function, fast_osc_clock, slow_osc_clock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, tick, t0;
    logic        pready, pslverr, sys_clk, gear_clock, prescaler_clock, clock_out_pin_o;
    logic        clock_out_pin_oe, fast_osc_enable, slow_osc_enable, fast_osc_drive_strength;
    logic        slow_osc_drive_strength, ext_clock_buffer_mode, fast_osc_x2_force_high;
    logic        addr_latch_oe, write_guard_active;
    logic [7:0]  seed, d;
    logic [2:0]  g;
    int          num_errors, samples_checked, p, r;
    clock_gear_guard i_clock_gear_guard (
        .clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .fast_osc_clock, .slow_osc_clock, .stop_mode, .clkout_pin_direction, .clkout_pin_function,
        .sys_clk, .gear_clock, .prescaler_clock, .clock_out_pin_o, .clock_out_pin_oe,
        .fast_osc_enable, .slow_osc_enable, .fast_osc_drive_strength, .slow_osc_drive_strength,
        .ext_clock_buffer_mode, .fast_osc_x2_force_high, .addr_latch_oe, .write_guard_active);
    // 50 ns clock
    initial clk = 1'b0;
    always #25 clk = ~clk;
    // oscillator stand-ins: fast period 4, slow period 32, stopped when disabled
    always @(posedge clk) begin
        tick           <= tick + 32'h0000_0001;
        fast_osc_clock <= tick[1] & fast_osc_enable;
        slow_osc_clock <= tick[4] & slow_osc_enable;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [31:0] gear_period(input logic [2:0] c);
        return 32'h0000_0004 << c;
    endfunction
    function automatic logic pick(input int s);
        return s == 0 ? gear_clock : s == 1 ? prescaler_clock : s == 2 ? sys_clk : clock_out_pin_o;
    endfunction
    function automatic logic [7:0] pins();
        return {fast_osc_enable, slow_osc_enable, write_guard_active, addr_latch_oe,
                ext_clock_buffer_mode, fast_osc_x2_force_high, fast_osc_drive_strength,
                slow_osc_drive_strength};
    endfunction
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", s, e, v);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] wd);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {a, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        check("pready", 32'h0000_0001, 32'(pready));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles between the second and third rising edge of a clock output
    task automatic period(input int s);
        prv = pick(s);
        r = 0;
        p = 0;
        for (int k = 0; k < 3000 && r < 3; k++) begin
            @(posedge clk);
            cur = pick(s);
            if (cur && !prv) r++;
            if (r == 2) p++;
            prv = cur;
        end
    endtask
    // start warm-up, poll busy, compare the span in cycles with the expected span
    task automatic warm(input logic [7:0] c2, input logic [31:0] span);
        apb(1, `CG_IDX_CTRL2, c2);
        apb(1, `CG_IDX_CTRL0, 8'hc4);
        t0 = tick;
        apb(0, `CG_IDX_CTRL0, 8'h00);
        check("warm-up busy", 32'h0000_0001, 32'(rd[2]));
        while (rd[2] === 1'b1 && tick - t0 < 32'h0002_0000) apb(0, `CG_IDX_CTRL0, 8'h00);
        check("warm-up span", 32'h0000_0001, 32'(tick - t0 + 64 >= span && tick - t0 <= span + 64));
        $display("test warm-up %h finished", c2);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("unexpected run length: expected end, seen timeout");
        end_of_test();
    end
    // main sequence
    initial begin
        {rst_n, ce, psel, penable, pwrite, stop_mode, clkout_pin_direction} = 7'h20;
        {clkout_pin_function, fast_osc_clock, slow_osc_clock, paddr, pwdata, tick} = 79'h0;
        {seed, num_errors, samples_checked} = {8'h4f, 64'h0};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, `CG_IDX_CTRL1, 8'h00);
        check("reset gear", 32'h0000_0004, rd & 32'h0000_000f);
        apb(0, `CG_IDX_NOISE, 8'h00);
        check("reset noise", 32'h0000_0003, rd & 32'h0000_00ab);
        check("reset pins", 32'h0000_0083, 32'(pins()));
        period(2);
        check("reset sys period", gear_period(3'h4) << 1, p);
        $display("test reset finished");
        // gear codes 0 to 4 then random ones, each followed by an unmapped write
        for (int i = 0; i < 8; i++) begin
            g = i < 5 ? 3'(i) : 3'(seed % 8'h05);
            seed = lfsr(seed);
            apb(1, `CG_IDX_CTRL1, {5'h00, g});
            apb(1, 10'h3f0, 8'h00);
            check("unmapped error", 32'h0000_0001, 32'(err));
            period(0);
            check("gear period", gear_period(g), p);
            period(2);
            check("sys period", gear_period(g) << 1, p);
            period(1);
            check("prescaler period", gear_period(g) << 1, p);
        end
        apb(1, `CG_IDX_CTRL0, 8'h81);
        period(1);
        check("fast/16 prescaler", gear_period(3'h4) << 1, p);
        $display("test gear finished");
        // random noise controls, fast drive kept normal
        for (int i = 0; i < 4; i++) begin
            d = (seed & 8'h29) | 8'h02;
            seed = lfsr(seed);
            apb(1, `CG_IDX_NOISE, d);
            @(posedge clk);
            check("noise pins", 32'({3'h4, d[5], d[3], d[3], 1'b1, d[0]}), 32'(pins()));
            apb(0, `CG_IDX_NOISE, 8'h00);
            check("noise read", 32'(d), rd & 32'h0000_00ab);
        end
        // guard on refuses clock register writes, key stays writable
        apb(1, `CG_IDX_KEY, seed | 8'h20);
        for (int i = 0; i < 4; i++) apb(1, `CG_IDX_CTRL0 + 10'(i), 8'h00);
        apb(0, `CG_IDX_CTRL1, 8'h00);
        check("guarded gear", 32'(g), rd & 32'h0000_000f);
        apb(0, `CG_IDX_NOISE, 8'h00);
        check("guard flag", 32'h0000_0001, 32'(rd[7]));
        check("guarded enable", 32'h0000_0001, 32'(fast_osc_enable));
        apb(1, `CG_IDX_KEY, `CG_GUARD_KEY);
        @(posedge clk);
        check("guard off", 32'h0000_0000, 32'(write_guard_active));
        $display("test guard finished");
        apb(1, `CG_IDX_CTRL1, 8'h04);
        warm(8'h10, 32'h0000_2000);
        apb(1, `CG_IDX_CTRL1, 8'h0c);
        period(2);
        check("slow sys period", 32'h0000_0020, p);
        warm(8'h10, 32'h0000_0400);
        warm(8'h20, 32'h0001_0000);
        apb(1, `CG_IDX_CTRL0, 8'h40);
        @(posedge clk);
        check("fast stopped", 32'h0000_0001, 32'({fast_osc_enable, slow_osc_enable} == 2'h1));
        apb(1, `CG_IDX_CTRL0, 8'hc0);
        apb(1, `CG_IDX_CTRL1, 8'h04);
        // clock-out source, then frozen in stop mode
        clkout_pin_direction <= 1'b1;
        clkout_pin_function <= 1'b1;
        apb(1, `CG_IDX_CTRL2, 8'h00);
        period(3);
        check("clock-out slow", 32'h0000_0020, p);
        check("clock-out enable", 32'h0000_0001, 32'(clock_out_pin_oe));
        apb(1, `CG_IDX_CTRL2, 8'h40);
        period(3);
        check("clock-out gear", gear_period(3'h4), p);
        stop_mode <= 1'b1;
        repeat (4) @(posedge clk);
        prv = clock_out_pin_o;
        r = 0;
        repeat (130) @(posedge clk) r += int'(clock_out_pin_o !== prv);
        check("stopped clock-out", 32'h0000_0000, r);
        $display("test clock-out finished");
        end_of_test();
    end
endmodule
